// ### core/ddr_quad_io_read.sv
// double-data-rate quad read engine of a serial flash, device side
// assumes host drives sck and cs_n; array read is combinational on mem_addr_o
`timescale 1ns/1ps
// Notes on behaviour
// - EDh takes 3 or 4 address bytes by width bit; EEh always 4.
// - read instruction accepted only when quad enable or quad-peripheral bit is set; continuous frames are not checked.
// - address taken a nibble per sck edge, both edges, on four lines.
// - after address, mode, latency: data a nibble per edge on both edges.
// - dummy cycles between mode and data, count from latency field.
// - complementary mode nibbles enter continuous mode; next frame starts at address.
// - non-complementary mode nibbles leave continuous mode at the next frame.
// - mode reset command leaves continuous mode, back to instruction decode.
// - address increments per output byte, wraps from top to zero.
// - preamble driven during the four cycles just before first data.
// - preamble pattern driven identically on all four lines.
// - four-wire instruction mode takes instruction a nibble per rising edge.
// - continuous mode omits the instruction phase entirely.
module ddr_quad_io_read (
  // clock and reset
  input  wire logic                                    clk_i,
  input  wire logic                                    reset_i,
  // serial pins
  input  wire logic                                    sck_i,
  input  wire logic                                    cs_n_i,
  input  wire logic [3:0]                              quad_io_lines_i,
  output logic      [3:0]                              quad_io_lines_o,
  output logic      [3:0]                              quad_io_lines_oe_o,
  // configuration
  input  wire ddr_quad_read_pkg::cfg_t                 cfg_i,
  // array read port
  output logic      [ddr_quad_read_pkg::ARRAY_ADDR_W-1:0] mem_addr_o,
  input  wire logic [7:0]                              mem_data_i,
  // status
  output logic                                         cont_mode_o
);

  // ==========================================================
  // pin sampling
  ddr_quad_read_pkg::pins_t pins_raw;
  ddr_quad_read_pkg::pins_t pins;
  logic [5:0]               pins_q;

  assign pins_raw = '{sck: sck_i, cs_n: cs_n_i, io: quad_io_lines_i};

  pin_sync3 #(
    .W   (6),
    .RST (ddr_quad_read_pkg::PINS_RESET)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (pins_raw),
    .q_o     (pins_q)
  );

  assign pins = ddr_quad_read_pkg::pins_t'(pins_q);

  // ==========================================================
  // state
  ddr_quad_read_pkg::state_t                state_reg, state_next;
  logic                                     sck_prev_reg, cs_prev_reg;
  logic [3:0]                               cnt_reg, cnt_next;
  logic [31:0]                              shift_reg, shift_next;
  logic [ddr_quad_read_pkg::ARRAY_ADDR_W-1:0] addr_reg, addr_next;
  logic                                     four_reg, four_next;
  logic                                     cont_reg, cont_next;
  logic                                     pend_reg, pend_next;
  logic [3:0]                               mode_hi_reg, mode_hi_next;
  logic [7:0]                               pre_reg, pre_next;
  logic [3:0]                               io_reg, io_next;
  logic                                     oe_reg, oe_next;

  logic       rise;
  logic       fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       four_wire;
  logic       quad_ok;
  logic       dlp_en;
  logic [3:0] lat;
  logic [3:0] cnt_inc;
  logic [3:0] cmd_edges;
  logic [7:0] cmd_byte;

  assign rise      = pins.sck & ~sck_prev_reg;
  assign fall      = ~pins.sck & sck_prev_reg;
  assign cs_fall   = ~pins.cs_n & cs_prev_reg;
  assign cs_rise   = pins.cs_n & ~cs_prev_reg;
  assign four_wire = cfg_i.config_two_volatile[ddr_quad_read_pkg::FOUR_WIRE_BIT];
  assign quad_ok   = cfg_i.config_one_volatile[ddr_quad_read_pkg::QUAD_EN_BIT]
                   | cfg_i.config_two_volatile[ddr_quad_read_pkg::QUAD_PERIPH_BIT];
  assign dlp_en    = cfg_i.data_learning_preamble_en;
  assign lat       = cfg_i.config_three_volatile[ddr_quad_read_pkg::LATENCY_LSB +:
                                                 ddr_quad_read_pkg::LATENCY_W];
  assign cnt_inc   = cnt_reg + 4'h1;
  assign cmd_edges = four_wire ? ddr_quad_read_pkg::CMD_EDGES_FOUR_WIRE
                               : ddr_quad_read_pkg::CMD_EDGES_SERIAL;
  assign cmd_byte  = four_wire ? {shift_reg[3:0], pins.io}
                               : {shift_reg[6:0], pins.io[0]};

  // ==========================================================
  // next state
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    addr_next    = addr_reg;
    four_next    = four_reg;
    cont_next    = cont_reg;
    pend_next    = pend_reg;
    mode_hi_next = mode_hi_reg;
    pre_next     = pre_reg;
    io_next      = io_reg;
    oe_next      = oe_reg;
    if (pins.cs_n) begin
      state_next = ddr_quad_read_pkg::ST_IDLE;
      oe_next    = 1'b0;
      if (cs_rise && state_reg != ddr_quad_read_pkg::ST_IDLE) begin
        cont_next = pend_reg;
      end
    end else if (cs_fall) begin
      state_next = cont_reg ? ddr_quad_read_pkg::ST_ADDR : ddr_quad_read_pkg::ST_CMD;
      cnt_next   = 4'h0;
      shift_next = 32'h0000_0000;
    end else begin
      case (state_reg)
        ddr_quad_read_pkg::ST_CMD: begin
          if (rise) begin
            shift_next = {shift_reg[23:0], cmd_byte};
            cnt_next   = cnt_inc;
          end else if (fall && cnt_reg == cmd_edges) begin
            // decode on the fall that closes the last instruction cycle
            cnt_next = 4'h0;
            if ((shift_reg[7:0] == ddr_quad_read_pkg::CMD_READ_SEL ||
                 shift_reg[7:0] == ddr_quad_read_pkg::CMD_READ_FOUR) && quad_ok) begin
              state_next = ddr_quad_read_pkg::ST_ADDR;
              four_next  = (shift_reg[7:0] == ddr_quad_read_pkg::CMD_READ_FOUR) |
                           cfg_i.config_two_volatile[ddr_quad_read_pkg::ADDR_FOUR_BIT];
            end else if (shift_reg[7:0] == ddr_quad_read_pkg::CMD_MODE_RESET) begin
              cont_next  = 1'b0;
              pend_next  = 1'b0;
              state_next = ddr_quad_read_pkg::ST_IGNORE;
            end else begin
              state_next = ddr_quad_read_pkg::ST_IGNORE;
            end
          end
        end
        ddr_quad_read_pkg::ST_ADDR: begin
          if (rise || fall) begin
            shift_next = {shift_reg[27:0], pins.io};
            cnt_next   = cnt_inc;
            if (cnt_inc == (four_reg ? ddr_quad_read_pkg::ADDR4_NIBBLES
                                     : ddr_quad_read_pkg::ADDR3_NIBBLES)) begin
              addr_next  = shift_next[ddr_quad_read_pkg::ARRAY_ADDR_W-1:0];
              state_next = ddr_quad_read_pkg::ST_MODE;
            end
          end
        end
        ddr_quad_read_pkg::ST_MODE: begin
          if (rise) begin
            mode_hi_next = pins.io;
          end else if (fall) begin
            pend_next = (mode_hi_reg == ~pins.io);
            cnt_next  = 4'h0;
            if (lat == 4'h0) begin
              state_next = ddr_quad_read_pkg::ST_DATA;
              io_next    = mem_data_i[7:4];
              oe_next    = 1'b1;
            end else begin
              state_next = ddr_quad_read_pkg::ST_DUMMY;
              if (dlp_en && lat == ddr_quad_read_pkg::PREAMBLE_CYCLES) begin
                io_next  = {4{cfg_i.data_learning_preamble[7]}};
                pre_next = {cfg_i.data_learning_preamble[6:0], 1'b0};
                oe_next  = 1'b1;
              end
            end
          end
        end
        ddr_quad_read_pkg::ST_DUMMY: begin
          if (fall) begin
            cnt_next = cnt_inc;
            if (cnt_inc == lat) begin
              state_next = ddr_quad_read_pkg::ST_DATA;
              io_next    = mem_data_i[7:4];
              oe_next    = 1'b1;
            end else if (dlp_en && lat > ddr_quad_read_pkg::PREAMBLE_CYCLES &&
                         cnt_inc == lat - ddr_quad_read_pkg::PREAMBLE_CYCLES) begin
              io_next  = {4{cfg_i.data_learning_preamble[7]}};
              pre_next = {cfg_i.data_learning_preamble[6:0], 1'b0};
              oe_next  = 1'b1;
            end else if (oe_reg) begin
              io_next  = {4{pre_reg[7]}};
              pre_next = {pre_reg[6:0], 1'b0};
            end
          end else if (rise && oe_reg) begin
            io_next  = {4{pre_reg[7]}};
            pre_next = {pre_reg[6:0], 1'b0};
          end
        end
        ddr_quad_read_pkg::ST_DATA: begin
          if (rise) begin
            io_next   = mem_data_i[3:0];
            addr_next = addr_reg + 1'b1;
          end else if (fall) begin
            io_next = mem_data_i[7:4];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg    <= ddr_quad_read_pkg::ST_IDLE;
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
      cnt_reg      <= 4'h0;
      shift_reg    <= 32'h0000_0000;
      addr_reg     <= '0;
      four_reg     <= 1'b0;
      cont_reg     <= 1'b0;
      pend_reg     <= 1'b0;
      mode_hi_reg  <= 4'h0;
      pre_reg      <= 8'h00;
      io_reg       <= 4'h0;
      oe_reg       <= 1'b0;
    end else begin
      state_reg    <= state_next;
      sck_prev_reg <= pins.sck;
      cs_prev_reg  <= pins.cs_n;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      addr_reg     <= addr_next;
      four_reg     <= four_next;
      cont_reg     <= cont_next;
      pend_reg     <= pend_next;
      mode_hi_reg  <= mode_hi_next;
      pre_reg      <= pre_next;
      io_reg       <= io_next;
      oe_reg       <= oe_next;
    end
  end

  assign quad_io_lines_o    = io_reg;
  assign quad_io_lines_oe_o = {4{oe_reg}};
  assign mem_addr_o         = addr_reg;
  assign cont_mode_o        = cont_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_data_rise;
    state_reg == ddr_quad_read_pkg::ST_DATA && !pins.cs_n && rise;
  endsequence

  sequence s_mode_fall;
    state_reg == ddr_quad_read_pkg::ST_MODE && !pins.cs_n && !cs_fall && fall;
  endsequence

  chk_addr_incr: assert property (s_data_rise |=> addr_reg == $past(addr_reg) + 1'b1)
    else $error("read address did not advance by one");
  chk_data_low: assert property (s_data_rise |=> io_reg == $past(mem_data_i[3:0]))
    else $error("lower nibble not driven on rising edge");
  chk_cont_entry: assert property (s_mode_fall ##0 (mode_hi_reg == ~pins.io) |=> pend_reg)
    else $error("complementary mode byte did not arm continuous mode");
  chk_cont_leave: assert property (s_mode_fall ##0 (mode_hi_reg != ~pins.io) |=> !pend_reg)
    else $error("non-complementary mode byte kept continuous mode");
  chk_no_quad: assert property (state_reg == ddr_quad_read_pkg::ST_CMD && !quad_ok
                                |=> state_reg != ddr_quad_read_pkg::ST_ADDR)
    else $error("read accepted without quad capability");
  chk_cont_skip: assert property (cs_fall && !pins.cs_n && cont_reg
                                  |=> state_reg == ddr_quad_read_pkg::ST_ADDR)
    else $error("continuous frame did not start at address");
  chk_preamble_same: assert property (oe_reg && state_reg == ddr_quad_read_pkg::ST_DUMMY
                                      |-> io_reg == {4{io_reg[0]}})
    else $error("preamble differs between lines");
  chk_release: assert property (pins.cs_n |=> !oe_reg ##1 !oe_reg or !pins.cs_n)
    else $error("lines driven while deselected");
  chk_dummy_quiet: assert property (state_reg == ddr_quad_read_pkg::ST_DUMMY && !dlp_en
                                    |-> !oe_reg)
    else $error("lines driven during dummy cycles without preamble");

endmodule

// ### core/ddr_quad_read_pkg.sv
// constants, carriers and states of the double-data-rate quad read engine
// assumes one 125 MHz clock that samples the serial pins
package ddr_quad_read_pkg;

  // ==========================================================
  // instructions
  localparam logic [7:0] CMD_READ_SEL   = 8'hED;
  localparam logic [7:0] CMD_READ_FOUR  = 8'hEE;
  localparam logic [7:0] CMD_MODE_RESET = 8'hFF;

  // ==========================================================
  // configuration field positions
  localparam int ADDR_FOUR_BIT    = 0;  // in config_two_volatile
  localparam int QUAD_EN_BIT      = 1;  // in config_one_volatile
  localparam int QUAD_PERIPH_BIT  = 1;  // in config_two_volatile
  localparam int FOUR_WIRE_BIT    = 3;  // in config_two_volatile
  localparam int LATENCY_LSB      = 0;  // in config_three_volatile
  localparam int LATENCY_W        = 4;

  // ==========================================================
  // counts
  localparam logic [3:0] CMD_EDGES_SERIAL    = 4'h8;
  localparam logic [3:0] CMD_EDGES_FOUR_WIRE = 4'h2;
  localparam logic [3:0] ADDR3_NIBBLES       = 4'h6;
  localparam logic [3:0] ADDR4_NIBBLES       = 4'h8;
  localparam logic [3:0] PREAMBLE_CYCLES     = 4'h4;
  localparam int         ARRAY_ADDR_W        = 23;

  // ==========================================================
  // reset values
  localparam logic [5:0] PINS_RESET = 6'h10;  // chip select idle high

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic [3:0] io;
  } pins_t;

  typedef struct packed {
    logic [7:0] config_one_volatile;
    logic [7:0] config_two_volatile;
    logic [7:0] config_three_volatile;
    logic       data_learning_preamble_en;
    logic [7:0] data_learning_preamble;
  } cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } state_t;

endpackage

// ### core/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs asynchronous to clk_i
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // pins
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // a bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
      q_reg  <= RST;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule

// ### test/host_spi_model.sv
// host side of the serial link: drives clock, select and the four lines
// assumes the bench resolves the shared lines and feeds them back on io_i
`timescale 1ns/1ps
module host_spi_model (
  // link toward the device
  output logic            sck_o,
  output logic            cs_n_o,
  output logic      [3:0] io_o,
  output logic            io_oe_o,
  // resolved line levels
  input  wire logic [3:0] io_i
);
  logic [3:0] cap[$];

  initial begin
    sck_o   = 1'b0;
    cs_n_o  = 1'b1;
    io_o    = 4'h0;
    io_oe_o = 1'b0;
  end

  // ==========================================================
  // half period of 40 ns; released lines toggle instead of holding
  task automatic half(input logic [3:0] v, input bit drive, input bit keep);
    io_oe_o = drive;
    io_o    = drive ? v : ~io_o;
    #20;
    sck_o = ~sck_o;
    #20;
    // fixed capture skew: 60 ns after the launching edge, 20 ns after the next edge
    if (keep) cap.push_back(io_i);
  endtask

  // ==========================================================
  // one frame; kind 0 no instruction, 1 serial, 2 four-wire
  task automatic frame(input logic [7:0] cmd, input int kind, input int nib,
                       input logic [31:0] addr, input logic [7:0] mode,
                       input int lat, input int nb);
    int i;
    cap.delete();
    cs_n_o = 1'b0;
    #40;
    if (kind == 1) begin
      for (i = 7; i >= 0; i--) begin
        half({3'h0, cmd[i]}, 1, 0);
        half({3'h0, cmd[i]}, 1, 0);
      end
    end
    if (kind == 2) begin
      for (i = 1; i >= 0; i--) begin
        half(cmd[4*i+:4], 1, 0);
        half(cmd[4*i+:4], 1, 0);
      end
    end
    for (i = nib - 1; i >= 0; i--) half(addr[4*i+:4], 1, 0);
    if (nib > 0) begin
      half(mode[7:4], 1, 0);
      half(mode[3:0], 1, 0);
      for (i = 0; i < 2 * (lat + nb); i++) half(4'h0, 0, 1);
    end
    cs_n_o  = 1'b1;
    io_oe_o = 1'b0;
    #80;
  endtask
endmodule

// ### test/tb.sv
// self-checking bench of the double-data-rate quad read engine
// assumes host_spi_model as far side and a fixed memory pattern
`timescale 1ns/1ps
module tb;
  logic                    clk_i     = 1'b0;
  logic                    reset_i   = 1'b1;
  ddr_quad_read_pkg::cfg_t cfg       = '0;
  logic                    sck;
  logic                    cs_n;
  logic                    host_oe;
  logic                    cont;
  logic [3:0]              host_io;
  logic [3:0]              dut_io;
  logic [3:0]              dut_oe;
  logic [3:0]              io_wire;
  logic [22:0]             mem_addr;
  logic [7:0]              mem_data;
  int                      n_fail    = 0;
  int                      cmp_count = 0;
  int                      cycles    = 0;
  int                      oe_cnt    = 0;
  int                      cur_nib   = 6;
  bit                      cont_exp  = 1'b0;
  int                      seed;
  int                      k;

  function automatic logic [7:0] mem_byte(input logic [22:0] a);
    return a[7:0] ^ a[15:8] ^ {1'b0, a[22:16]} ^ 8'hA5;
  endfunction

  always #4 clk_i = ~clk_i;
  assign io_wire  = (dut_oe != 4'h0) ? dut_io : host_io;
  assign mem_data = mem_byte(mem_addr);

  host_spi_model host (
    .sck_o   (sck),
    .cs_n_o  (cs_n),
    .io_o    (host_io),
    .io_oe_o (host_oe),
    .io_i    (io_wire)
  );

  ddr_quad_io_read uut (
    .clk_i              (clk_i),
    .reset_i            (reset_i),
    .sck_i              (sck),
    .cs_n_i             (cs_n),
    .quad_io_lines_i    (io_wire),
    .quad_io_lines_o    (dut_io),
    .quad_io_lines_oe_o (dut_oe),
    .cfg_i              (cfg),
    .mem_addr_o         (mem_addr),
    .mem_data_i         (mem_data),
    .cont_mode_o        (cont)
  );

  // ==========================================================
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(negedge clk_i) begin
    cycles++;
    if (!reset_i && dut_oe !== 4'h0) begin
      oe_cnt++;
      check(dut_oe, 4'hF);
      check(host_oe, 1'b0);
    end
    if (cycles == 40000) begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================================
  // stimulus and reference model
  task automatic setcfg(input logic [7:0] c1, input logic [7:0] c2,
                        input logic [7:0] c3, input logic en, input logic [7:0] pat);
    @(posedge clk_i);
    cfg <= {c1, c2, c3, en, pat};
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [31:0] addr,
                    input logic [7:0] mode, input int nb);
    int          lat;
    int          kind;
    int          b;
    bit          acc;
    logic [22:0] a;
    lat  = int'(cfg.config_three_volatile[3:0]);
    kind = cont_exp ? 0 : (cfg.config_two_volatile[3] ? 2 : 1);
    if (kind != 0)
      cur_nib = (cmd == 8'hFF) ? 0 :
                ((cmd == 8'hEE || cfg.config_two_volatile[0]) ? 8 : 6);
    acc = (kind == 0) || ((cmd == 8'hED || cmd == 8'hEE) &&
          (cfg.config_one_volatile[1] || cfg.config_two_volatile[1]));
    // start the frame off the sampling edge so no pin moves at a clock edge
    @(posedge clk_i);
    #2;
    oe_cnt = 0;
    host.frame(cmd, kind, cur_nib, addr, mode, lat, nb);
    if (!acc) check(oe_cnt, 0);
    if (acc && cfg.data_learning_preamble_en && lat >= 4)
      for (b = 0; b < 8; b++)
        check(host.cap[2*lat-8+b], {4{cfg.data_learning_preamble[7-b]}});
    a = addr[22:0];
    for (b = 0; b < nb && acc; b++) begin
      check({host.cap[2*lat+2*b], host.cap[2*lat+2*b+1]}, mem_byte(a));
      a = a + 23'h1;
    end
    if (acc) cont_exp = (mode[7:4] == ~mode[3:0]);
    if (kind != 0 && cmd == 8'hFF) cont_exp = 1'b0;
    check(cont, cont_exp);
  endtask

  initial begin
    seed = $urandom(66758);
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    #1;
    check(cont, 1'b0);
    check(mem_addr, 23'h0);
    setcfg(8'h02, 8'h00, 8'h02, 1'b0, 8'h00);
    rd(8'hED, $urandom, 8'h00, 3);
    setcfg(8'h00, 8'h02, 8'h05, 1'b1, 8'h34);
    rd(8'hEE, 32'hFF7FFFFE, 8'h00, 4);
    setcfg(8'h02, 8'h01, 8'h04, 1'b1, 8'($urandom));
    rd(8'hED, $urandom, 8'h00, 2);
    setcfg(8'h00, 8'h00, 8'h03, 1'b0, 8'h00);
    rd(8'hED, 32'h1234, 8'h00, 2);
    setcfg(8'h02, 8'h08, 8'h00, 1'b1, 8'h34);
    rd(8'h0B, 32'h10, 8'h00, 1);
    rd(8'hED, 32'h7FFFFF, 8'h00, 2);
    setcfg(8'h02, 8'h00, 8'h06, 1'b1, 8'hC9);
    rd(8'hED, 32'h100, 8'h5A, 2);
    rd(8'h00, 32'h200, 8'hA5, 2);
    rd(8'h00, 32'h300, 8'h00, 1);
    rd(8'hED, 32'h400, 8'hC3, 1);
    rd(8'h00, 32'hFFFFFFFF, 8'hFF, 1);
    rd(8'hFF, 32'h0, 8'h00, 0);
    for (k = 0; k < 12; k++) begin
      setcfg(8'h02, 8'($urandom) & 8'h0B, 8'($urandom_range(15, 0)), 1'($urandom),
             8'($urandom));
      rd(($urandom % 2) ? 8'hED : 8'hEE, $urandom, 8'($urandom), 1 + $urandom_range(2, 0));
    end
    summarize();
  end
endmodule
